// >>> inc/tlic_regs.svh
// Constants of the two-level interrupt controller: bit positions, vectors.
// Assumes inclusion by the controller and the bench; no logic here.
`ifndef TLIC_REGS_SVH
`define TLIC_REGS_SVH
`define TLIC_NSRC        11
// Request flag positions in timer_ctrl_reg
`define TLIC_TC_EXT0     1
`define TLIC_TC_EXT1     3
`define TLIC_TC_TMR0     5
`define TLIC_TC_TMR1     7
// Serial flag in serial_ctrl_reg, watchdog flag in wdog_ctrl_reg
`define TLIC_SC_SERIAL   7
`define TLIC_WD_FLAG     3
// Enable bit positions (main and extra registers)
`define TLIC_IE_GLOBAL   7
`define TLIC_IE_SERIAL   6
`define TLIC_EIE_WDOG    5
// Vector addresses, in priority order
`define TLIC_VEC_EXT0    8'h03
`define TLIC_VEC_TMR0    8'h0B
`define TLIC_VEC_EXT1    8'h13
`define TLIC_VEC_TMR1    8'h1B
`define TLIC_VEC_SERIAL  8'h3B
`define TLIC_VEC_EXT2    8'h43
`define TLIC_VEC_EXT3    8'h4B
`define TLIC_VEC_CID     8'h53
`define TLIC_VEC_DIV     8'h5B
`define TLIC_VEC_COMP    8'h63
`define TLIC_VEC_WDOG    8'h6B
// Reset values
`define TLIC_RST_BYTE    8'h00
`define TLIC_RST_SRC     11'h000
`endif

// >>> inc/tlic_pkg.sv
// Types of the two-level interrupt controller.
// Assumes the constants header is compiled alongside.
package tlic_pkg;
  // Source index, priority order, 0 is highest
  typedef enum logic [3:0] {
    TLIC_S_EXT0, TLIC_S_TMR0, TLIC_S_EXT1, TLIC_S_TMR1, TLIC_S_SERIAL,
    TLIC_S_EXT2, TLIC_S_EXT3, TLIC_S_CID, TLIC_S_DIV, TLIC_S_COMP, TLIC_S_WDOG
  } tlic_src_type;
endpackage

// >>> src/tlic_ctrl.sv
// Two-level priority interrupt controller with flags, enables, vectoring.
// Assumes a CPU core that gives one-cycle machine-cycle strobes on CLK and
// peripheral event pulses on the same clock; pins are asynchronous.
`timescale 1ns/100ps
`include "tlic_regs.svh"

module tlic_ctrl (
  input  wire logic       CLK,                // 25 MHz system clock
  input  wire logic       NRST,               // Synchronous reset, low
  input  wire logic       MCYCLE,             // Machine cycle strobe
  input  wire logic       INSTR_LAST,         // Last cycle of instruction
  input  wire logic       INSTR_BLOCK,        // Writes enable/prio regs
  input  wire logic       RETI_EXEC,          // Return-from-interrupt
  input  wire logic       EXT_INT_PIN_ZERO,   // Async pins
  input  wire logic       EXT_INT_PIN_ONE,
  input  wire logic       EXT_INT_PIN_TWO,
  input  wire logic       EXT_INT_PIN_THREE,
  input  wire logic       EDGE_SELECT_ZERO,   // High selects edge
  input  wire logic       EDGE_SELECT_ONE,
  input  wire logic       TMR_OVF_ZERO,       // Overflow pulses
  input  wire logic       TMR_OVF_ONE,
  input  wire logic       SERIAL_EVENT,       // Rx or Tx event pulse
  input  wire logic       DIVIDER_OVF,
  input  wire logic       COMPARATOR_RESULT,  // Synchronous level
  input  wire logic [7:0] CALLER_ID_FLAGS,    // Source-held flags
  input  wire logic       WDOG_TIMEOUT,       // Time-out pulse
  input  wire logic [7:0] MAIN_ENABLE_REG,
  input  wire logic [7:0] EXTRA_ENABLE_REG,
  input  wire logic [7:0] MAIN_PRIO_REG,
  input  wire logic [7:0] EXTRA_PRIO_REG,
  input  wire logic       FLAG_CLR_WE,        // Software flag clear
  input  wire logic [10:0] FLAG_CLR_MASK,     // Bits to clear, by source
  output logic [7:0]      TIMER_CTRL_FLAGS,   // Flag bits only
  output logic [7:0]      SERIAL_CTRL_FLAGS,
  output logic [7:0]      EXT_FLAG_REG,
  output logic [7:0]      WDOG_CTRL_FLAGS,
  output logic            VEC_CALL,           // One-cycle vector call
  output logic [7:0]      VEC_ADDR,
  output logic [1:0]      IN_SERVICE          // [1] high, [0] low
);

  // Pin synchronisers, two stages each
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  // Machine-cycle samples of synced pins
  logic [3:0] pin_samp_q;
  logic [10:0] flag_q;                        // Sticky flags
  logic [10:0] flag_d;
  logic        comp_prev_q;                   // Previous comparator
  logic [10:0] enab;                          // Per-source enables
  logic [10:0] prio;                          // Per-source priority
  logic [10:0] req;                           // Gated requests
  logic [10:0] req_hi;
  logic [10:0] req_lo;
  logic [10:0] win;                           // One-hot winner
  logic [10:0] svc_clr;                       // Hardware clears
  logic        take;
  logic        level0;
  logic        level1;
  logic [1:0]  insvc_q;
  logic        vcall_q;
  logic [7:0]  vaddr_q;

  // Two-stage synchronisers; reset to the idle high level of the pins,
  // so a strobe just after reset cannot see a false falling edge
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pin_s1_q <= 4'hF;
      pin_s2_q <= 4'hF;
    end else begin
      pin_s1_q <= {EXT_INT_PIN_THREE, EXT_INT_PIN_TWO, EXT_INT_PIN_ONE, EXT_INT_PIN_ZERO};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Pins sampled once per machine cycle
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pin_samp_q <= 4'hF;                     // Idle high, no false edge
    end else if (MCYCLE) begin
      pin_samp_q <= pin_s2_q;
    end
  end

  // Comparator history
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      comp_prev_q <= 1'b0;
    end else begin
      comp_prev_q <= COMPARATOR_RESULT;
    end
  end

  assign level0 = !EDGE_SELECT_ZERO;
  assign level1 = !EDGE_SELECT_ONE;

  // Enable map, priority mirrors it
  always_comb begin
    enab = {EXTRA_ENABLE_REG[`TLIC_EIE_WDOG:0],
            MAIN_ENABLE_REG[`TLIC_IE_SERIAL], MAIN_ENABLE_REG[3:0]};
    prio = {EXTRA_PRIO_REG[`TLIC_EIE_WDOG:0],
            MAIN_PRIO_REG[`TLIC_IE_SERIAL], MAIN_PRIO_REG[3:0]};
  end

  // Hardware clear on entry; level pins and caller-ID are not cleared
  always_comb begin
    svc_clr = take ? win : 11'h000;
    svc_clr[tlic_pkg::TLIC_S_EXT0] = svc_clr[tlic_pkg::TLIC_S_EXT0] & !level0;
    svc_clr[tlic_pkg::TLIC_S_EXT1] = svc_clr[tlic_pkg::TLIC_S_EXT1] & !level1;
    svc_clr[tlic_pkg::TLIC_S_CID]  = 1'b0;
  end

  // Flag next value: clear first, then sets win
  always_comb begin
    flag_d = flag_q & ~svc_clr;
    if (FLAG_CLR_WE) begin
      flag_d = flag_d & ~FLAG_CLR_MASK;
    end
    // Level mode tracks pin; edge mode catches high-then-low sample
    if (level0) begin
      flag_d[tlic_pkg::TLIC_S_EXT0] = !pin_samp_q[0];
    end else if (MCYCLE && pin_samp_q[0] && !pin_s2_q[0]) begin
      flag_d[tlic_pkg::TLIC_S_EXT0] = 1'b1;
    end
    if (level1) begin
      flag_d[tlic_pkg::TLIC_S_EXT1] = !pin_samp_q[1];
    end else if (MCYCLE && pin_samp_q[1] && !pin_s2_q[1]) begin
      flag_d[tlic_pkg::TLIC_S_EXT1] = 1'b1;
    end
    if (MCYCLE && pin_samp_q[2] && !pin_s2_q[2]) begin
      flag_d[tlic_pkg::TLIC_S_EXT2] = 1'b1;
    end
    if (MCYCLE && pin_samp_q[3] && !pin_s2_q[3]) begin
      flag_d[tlic_pkg::TLIC_S_EXT3] = 1'b1;
    end
    if (TMR_OVF_ZERO) begin
      flag_d[tlic_pkg::TLIC_S_TMR0] = 1'b1;
    end
    if (TMR_OVF_ONE) begin
      flag_d[tlic_pkg::TLIC_S_TMR1] = 1'b1;
    end
    if (SERIAL_EVENT) begin
      flag_d[tlic_pkg::TLIC_S_SERIAL] = 1'b1;
    end
    if (DIVIDER_OVF) begin
      flag_d[tlic_pkg::TLIC_S_DIV] = 1'b1;
    end
    if (COMPARATOR_RESULT && !comp_prev_q) begin
      flag_d[tlic_pkg::TLIC_S_COMP] = 1'b1;
    end
    if (WDOG_TIMEOUT) begin
      flag_d[tlic_pkg::TLIC_S_WDOG] = 1'b1;
    end
    // Summary follows the source flags; software clears them there
    flag_d[tlic_pkg::TLIC_S_CID] = |CALLER_ID_FLAGS;
  end

  // Flag register
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      flag_q <= `TLIC_RST_SRC;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Requests are recomputed live each cycle, never latched
  always_comb begin
    req = MAIN_ENABLE_REG[`TLIC_IE_GLOBAL] ? (flag_q & enab) : 11'h000;
    req_hi = req & prio;
    req_lo = req & ~prio;
  end

  // Fixed-order pick: lowest index wins within the chosen level
  always_comb begin
    logic [10:0] pool;
    pool = (|req_hi) ? req_hi : req_lo;
    win = pool & (~pool + 11'h001);
  end

  // Vector call only if nothing of equal or higher level is in service
  always_comb begin
    take = 1'b0;
    if (MCYCLE && INSTR_LAST && !INSTR_BLOCK && !RETI_EXEC) begin
      if (|req_hi) begin
        take = !insvc_q[1];
      end else if (|req_lo) begin
        take = !insvc_q[1] && !insvc_q[0];
      end
    end
  end

  // In-service levels; only return-from-interrupt retires one
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      insvc_q <= 2'b00;
    end else if (take) begin
      if (|req_hi) begin
        insvc_q[1] <= 1'b1;
      end else begin
        insvc_q[0] <= 1'b1;
      end
    end else if (RETI_EXEC) begin
      if (insvc_q[1]) begin
        insvc_q[1] <= 1'b0;
      end else begin
        insvc_q[0] <= 1'b0;
      end
    end
  end

  // Vector encode, one-hot winner to address
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      vcall_q <= 1'b0;
      vaddr_q <= `TLIC_RST_BYTE;
    end else begin
      vcall_q <= take;
      if (take) begin
        case (1'b1)
          win[0]:  vaddr_q <= `TLIC_VEC_EXT0;
          win[1]:  vaddr_q <= `TLIC_VEC_TMR0;
          win[2]:  vaddr_q <= `TLIC_VEC_EXT1;
          win[3]:  vaddr_q <= `TLIC_VEC_TMR1;
          win[4]:  vaddr_q <= `TLIC_VEC_SERIAL;
          win[5]:  vaddr_q <= `TLIC_VEC_EXT2;
          win[6]:  vaddr_q <= `TLIC_VEC_EXT3;
          win[7]:  vaddr_q <= `TLIC_VEC_CID;
          win[8]:  vaddr_q <= `TLIC_VEC_DIV;
          win[9]:  vaddr_q <= `TLIC_VEC_COMP;
          win[10]: vaddr_q <= `TLIC_VEC_WDOG;
          default: vaddr_q <= vaddr_q;
        endcase
      end
    end
  end

  // Status register images, flags at their bit positions
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      TIMER_CTRL_FLAGS  <= `TLIC_RST_BYTE;
      SERIAL_CTRL_FLAGS <= `TLIC_RST_BYTE;
      EXT_FLAG_REG      <= `TLIC_RST_BYTE;
      WDOG_CTRL_FLAGS   <= `TLIC_RST_BYTE;
    end else begin
      TIMER_CTRL_FLAGS  <= {flag_d[3], 1'b0, flag_d[1], 1'b0,
                            flag_d[2], 1'b0, flag_d[0], 1'b0};
      SERIAL_CTRL_FLAGS <= {flag_d[4], 7'h00};
      EXT_FLAG_REG      <= {3'h0, flag_d[9:5]};
      WDOG_CTRL_FLAGS   <= {4'h0, flag_d[10], 3'h0};
    end
  end

  assign VEC_CALL   = vcall_q;
  assign VEC_ADDR   = vaddr_q;
  assign IN_SERVICE = insvc_q;

  // Checks
  hi_block_a: assert property (@(posedge CLK) disable iff (!NRST)
    insvc_q[1] |-> !take) else $error("call while high in service");
  gate_off_a: assert property (@(posedge CLK) disable iff (!NRST)
    !MAIN_ENABLE_REG[7] |-> !take) else $error("call with global off");
  call_cond_a: assert property (@(posedge CLK) disable iff (!NRST)
    take |-> MCYCLE && INSTR_LAST && !RETI_EXEC && !INSTR_BLOCK)
    else $error("call outside allowed cycle");
  call_out_a: assert property (@(posedge CLK) disable iff (!NRST)
    take |=> VEC_CALL && VEC_ADDR[2:0] == 3'h3) else $error("vector not issued");
  edge_clr_a: assert property (@(posedge CLK) disable iff (!NRST)
    take && win[1] |=> !flag_q[1] || $past(TMR_OVF_ZERO))
    else $error("timer flag kept on entry");
  level_keep_a: assert property (@(posedge CLK) disable iff (!NRST)
    take && win[0] && level0 && !pin_samp_q[0] && !FLAG_CLR_WE |=> flag_q[0])
    else $error("level flag cleared");
  cmp_rise_a: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(COMPARATOR_RESULT) |=> flag_q[9]) else $error("comparator edge lost");
  cid_or_a: assert property (@(posedge CLK) disable iff (!NRST)
    (|CALLER_ID_FLAGS) |=> flag_q[7]) else $error("caller-ID summary wrong");
  hi_call_c: cover property (@(posedge CLK) take && (|req_hi));
  lo_call_c: cover property (@(posedge CLK) take && !(|req_hi));
  nest_c: cover property (@(posedge CLK) insvc_q == 2'b11);

endmodule // tlic_ctrl

// >>> verification/tlic_cpu_model.sv
// CPU core model: machine-cycle strobes, instruction end, service returns.
// Assumes the controller's CLK and NRST; everything moves on the falling edge.
`timescale 1ns/100ps

module tlic_cpu_model (
  input  wire logic CLK,        // System clock
  input  wire logic NRST,       // Sync reset, low
  input  wire logic RUN,        // Let instructions end
  input  wire logic AUTO_RETI,  // Return once routine is done
  input  wire logic VEC_CALL,   // Call from controller
  output logic      MCYCLE,     // One clock in four
  output logic      INSTR_LAST, // Follows RUN
  output logic      RETI_EXEC   // Pulse, with a strobe
);
  logic [1:0] phase_q; // Clock within machine cycle
  logic [3:0] depth_q; // Routines still open
  logic [2:0] wait_q;  // Machine cycles left in routine

  // Strobes and returns; routine length varies so returns come early or late
  always @(negedge CLK) begin
    if (!NRST) begin
      phase_q <= 2'h0;
      depth_q <= 4'h0;
      wait_q <= 3'h0;
      MCYCLE <= 1'b0;
      INSTR_LAST <= 1'b0;
      RETI_EXEC <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      MCYCLE <= (phase_q == 2'h3);
      INSTR_LAST <= RUN;
      RETI_EXEC <= 1'b0;
      // A call opens one more routine
      if (VEC_CALL) begin
        depth_q <= depth_q + 4'h1;
        wait_q <= 3'($urandom_range(2, 6));
      end else if (phase_q == 2'h3 && depth_q != 4'h0) begin
        // Return only at a strobe, never in the cycle of a call
        if (wait_q != 3'h0) begin
          wait_q <= wait_q - 3'h1;
        end else if (AUTO_RETI) begin
          RETI_EXEC <= 1'b1;
          depth_q <= depth_q - 4'h1;
          wait_q <= 3'h2;
        end
      end
    end
  end
endmodule // tlic_cpu_model

// >>> verification/tb_tlic_ctrl.sv
// Self-checking bench of the interrupt controller, random and corner cases.
// Assumes the CPU model file and the constants header on the include path.
`timescale 1ns/100ps
`include "tlic_regs.svh"

module tb_tlic_ctrl;
  logic        clk = 1'b0;      // System clock
  logic        nrst = 1'b0;     // Sync reset, low
  logic        run = 1'b0;      // Instruction ends allowed
  logic        auto_reti = 1'b1; // Model returns by itself
  logic        blk = 1'b0;      // Enable or priority write
  logic        comp = 1'b0;     // Comparator level
  logic        clr_we = 1'b0;   // Software flag clear
  logic [10:0] cmask = 11'h7FF; // Sources to clear, by index
  logic        glob = 1'b0;     // Global enable
  logic [3:0]  pins = 4'hF;     // Pins idle high
  logic [1:0]  esel = 2'h3;     // Edge select one, zero
  logic [7:0]  cid = 8'h00;     // Caller-ID flags
  logic [10:0] ev = 11'h000;    // Event pulses by source
  logic [10:0] ena = 11'h000;   // Enables by source
  logic [10:0] pri = 11'h000;   // Priorities by source
  logic [10:0] pend;            // Flags expected set
  logic        mcyc, ilast, reti, vec_call;
  logic [7:0]  tmr_fl, ser_fl, ext_fl, wd_fl, vec_addr;
  logic [1:0]  in_svc;          // In-service levels
  int          k;               // Source expected next
  int          failures = 0;
  int          checks_done = 0;
  // Vector table in source order
  logic [7:0]  vtab [11] = '{`TLIC_VEC_EXT0, `TLIC_VEC_TMR0, `TLIC_VEC_EXT1, `TLIC_VEC_TMR1,
    `TLIC_VEC_SERIAL, `TLIC_VEC_EXT2, `TLIC_VEC_EXT3, `TLIC_VEC_CID, `TLIC_VEC_DIV,
    `TLIC_VEC_COMP, `TLIC_VEC_WDOG};

  // 25 MHz clock
  always #20 clk = ~clk;

  tlic_cpu_model cpu (.CLK(clk), .NRST(nrst), .RUN(run), .AUTO_RETI(auto_reti),
    .VEC_CALL(vec_call), .MCYCLE(mcyc), .INSTR_LAST(ilast), .RETI_EXEC(reti));

  // Enable and priority layouts built from per-source vectors
  tlic_ctrl dut (.CLK(clk), .NRST(nrst), .MCYCLE(mcyc), .INSTR_LAST(ilast),
    .INSTR_BLOCK(blk), .RETI_EXEC(reti), .EXT_INT_PIN_ZERO(pins[0]),
    .EXT_INT_PIN_ONE(pins[1]), .EXT_INT_PIN_TWO(pins[2]), .EXT_INT_PIN_THREE(pins[3]),
    .EDGE_SELECT_ZERO(esel[0]), .EDGE_SELECT_ONE(esel[1]), .TMR_OVF_ZERO(ev[1]),
    .TMR_OVF_ONE(ev[3]), .SERIAL_EVENT(ev[4]), .DIVIDER_OVF(ev[8]),
    .COMPARATOR_RESULT(comp), .CALLER_ID_FLAGS(cid), .WDOG_TIMEOUT(ev[10]),
    .MAIN_ENABLE_REG({glob, ena[4], 2'b00, ena[3:0]}), .EXTRA_ENABLE_REG({2'b00, ena[10:5]}),
    .MAIN_PRIO_REG({1'b0, pri[4], 2'b00, pri[3:0]}), .EXTRA_PRIO_REG({2'b00, pri[10:5]}),
    .FLAG_CLR_WE(clr_we), .FLAG_CLR_MASK(cmask), .TIMER_CTRL_FLAGS(tmr_fl),
    .SERIAL_CTRL_FLAGS(ser_fl), .EXT_FLAG_REG(ext_fl), .WDOG_CTRL_FLAGS(wd_fl),
    .VEC_CALL(vec_call), .VEC_ADDR(vec_addr), .IN_SERVICE(in_svc));

  // Verdict and end of run
  task automatic report_and_stop;
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One comparison of any byte-wide result
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request flag of a source, wherever it lives
  function automatic logic fl(input int s);
    case (s)
      0: fl = tmr_fl[1];
      1: fl = tmr_fl[5];
      2: fl = tmr_fl[3];
      3: fl = tmr_fl[7];
      4: fl = ser_fl[7];
      10: fl = wd_fl[3];
      default: fl = ext_fl[s - 5];
    endcase
  endfunction

  // Highest fixed-order source in a mask
  function automatic int first(input logic [10:0] m);
    for (int i = 0; i < 11; i++) if (m[i]) return i;
    return 11;
  endfunction

  // One-cycle event pulses
  task automatic pulse(input logic [10:0] m);
    ev = m;
    @(negedge clk);
    ev = 11'h000;
  endtask

  // No call may appear for n cycles
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      chk("vec_call", 8'h00, 8'(vec_call));
    end
  endtask

  // Bounded wait for a call, then vector and in-service levels
  task automatic wait_call(input logic [7:0] va, input logic [1:0] sv);
    int n;
    n = 0;
    while (vec_call !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        chk("vec_call", 8'h01, 8'(vec_call));
        report_and_stop;
      end
    end
    chk("vec_addr", va, vec_addr);
    chk("in_service", 8'(sv), 8'(in_svc));
    @(negedge clk);
  endtask

  // Call for source s, then its flag as expected after entry
  task automatic svc(input int s, input logic keep);
    wait_call(vtab[s], 2'h1);
    chk("flag", 8'(keep), 8'(fl(s)));
  endtask

  // Pin held low until serviced; in edge mode it stays low 60 cycles more
  task automatic pin_test(input int p, input int s, input logic lvl);
    pins[p] = 1'b0;
    svc(s, lvl);
    if (lvl) pins[p] = 1'b1;
    quiet(60);
    pins[p] = 1'b1;
    quiet(12);
  endtask

  initial begin
    k = $urandom(53637);
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk("vec_addr", 8'h00, vec_addr);
    chk("tmr_flags", 8'h00, tmr_fl);
    // Random event sets; first pass with the global gate off
    for (int it = 0; it < 8; it++) begin
      run = 1'b0;
      pend = 11'($urandom) & 11'h51A;
      glob = (it != 0);
      ena = 11'($urandom);
      pulse(pend);
      run = 1'b1;
      while (glob && (pend & ena) != 11'h000) begin
        k = first(pend & ena);
        wait_call(vtab[k], 2'h1);
        pend[k] = 1'b0;
      end
      quiet(60);
      for (int s = 1; s < 11; s++) if (11'h51A >> s & 11'h001) chk("flag", 8'(pend[s]), 8'(fl(s)));
      // Random partial clear first, then the rest with the strobe held
      clr_we = 1'b1;
      cmask = 11'($urandom);
      pend = pend & ~cmask;
      @(negedge clk);
      for (int s = 1; s < 11; s++)
        if (11'h51A >> s & 11'h001) chk("flag_clr", 8'(pend[s]), 8'(fl(s)));
      cmask = 11'h7FF;
      @(negedge clk);
      clr_we = 1'b0;
    end
    // External pins: edge, level, edge-only
    ena = 11'h065;
    pin_test(0, 0, 1'b0);
    pin_test(1, 2, 1'b0);
    esel = 2'h0;
    pin_test(0, 0, 1'b1);
    pin_test(1, 2, 1'b1);
    pin_test(2, 5, 1'b0);
    pin_test(3, 6, 1'b0);
    esel = 2'h3;
    // Comparator rise, then caller-ID level
    ena = 11'h280;
    comp = 1'b1;
    svc(9, 1'b0);
    quiet(40);
    cid = 8'h40;
    svc(7, 1'b1);
    cid = 8'h00;
    quiet(60);
    // Blocked instruction end, then high over low
    ena = 11'h01A;
    pri = 11'h008;
    auto_reti = 1'b0;
    blk = 1'b1;
    pulse(11'h002);
    quiet(40);
    blk = 1'b0;
    wait_call(vtab[1], 2'h1);
    pulse(11'h008);
    wait_call(vtab[3], 2'h3);
    pulse(11'h010);
    quiet(60);
    auto_reti = 1'b1;
    wait_call(vtab[4], 2'h1);
    quiet(60);
    chk("in_service", 8'h00, 8'(in_svc));
    report_and_stop;
  end
endmodule // tb_tlic_ctrl
